//--- verilog/tai_pkg.sv
// Purpose: Shared constants and types for the application packet interface block.
// Assumes: One virtual channel, a 64-bit link word and a 32-bit APB register bus.
// Notes: Header layout follows the usual packet header, byte 0 in the top bits.
package tai_pkg;

    // ==========================================================================
    // Bus widths and descriptor fields
    // ==========================================================================
    localparam int HDR_W = 128;
    localparam int DEC_W = 8;
    localparam int DESC_W = HDR_W + DEC_W;
    localparam int DATA_W = 64;
    localparam int CRC_W = 32;
    localparam int DESC_FIRST_LO = 64;
    localparam int DESC_GROUP_HI = 127;
    localparam int DESC_HAS_DATA = 126;
    localparam int HDR_FMT_4DW = 125;
    localparam int HDR_TYPE_HI = 124;
    localparam int HDR_TYPE_LO = 120;
    localparam int DEC_RESERVED = 7;
    localparam logic [4:0] TYPE_CPL = 5'h0A;
    localparam logic [4:0] TYPE_MEM = 5'h00;
    localparam logic [1:0] TYPE_MSG_TOP = 2'h2;

    // ==========================================================================
    // Link check code
    // ==========================================================================
    localparam logic [CRC_W-1:0] LCRC_POLY = 32'h04C11DB7;
    localparam logic [CRC_W-1:0] LCRC_INIT = 32'hFFFFFFFF;

    // ==========================================================================
    // Register map
    // ==========================================================================
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] REG_TX_PKTS = 12'h008;
    localparam logic [ADDR_W-1:0] REG_TX_NULL = 12'h00C;
    localparam logic [ADDR_W-1:0] REG_RX_ACKS = 12'h010;
    localparam logic [ADDR_W-1:0] REG_RX_ABORTS = 12'h014;
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_TX_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STAT_TX_LO = 0;
    localparam int STAT_RX_LO = 4;
    localparam int STAT_TXCNT_LO = 8;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_FIRST = 2'b01,
        RX_HOLD = 2'b11
    } tai_rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PAD = 3'b001,
        TX_HDR0 = 3'b011,
        TX_HDR1 = 3'b010,
        TX_DATA = 3'b110,
        TX_CRC = 3'b111,
        TX_END = 3'b101
    } tai_tx_state_t;

    typedef enum logic [2:0] {
        LK_NONE = 3'h0,
        LK_HDR = 3'h1,
        LK_DATA = 3'h2,
        LK_LCRC = 3'h3,
        LK_END = 3'h4,
        LK_EDB = 3'h5
    } tai_lnk_kind_t;

    typedef struct packed {
        tai_lnk_kind_t kind;
        logic [DATA_W-1:0] data;
    } tai_lnk_word_t;

    typedef struct packed {
        logic [HDR_W-1:0] hdr;
        logic [DEC_W-1:0] dec;
    } tai_rx_hdr_t;

    typedef struct packed {
        logic last;
        logic [DATA_W-1:0] data;
    } tai_tx_entry_t;

endpackage

//--- verilog/tai_core.sv
// Purpose: Core side of the application packet interface, transmit and receive descriptor.
// Assumes: Receive buffer holds a header stable while rxb_valid is high until popped.
// Notes: Registers sit on APB with no wait states; an unmapped address answers pslverr.
`timescale 1ns/100ps

module tai_core
    import tai_pkg::*;
#(
    parameter int TX_BUF_DEPTH = 3,
    parameter int TX_FREE_PHASES = 2,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB register bus
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit application side, channel 0
    // Channel zero suffix.
    input wire logic tx_req0,
    input wire logic [HDR_W-1:0] tx_desc0,
    output logic tx_ack0,
    input wire logic tx_dfr0,
    input wire logic tx_dv0,
    input wire logic [DATA_W-1:0] tx_data0,
    input wire logic tx_err0,
    output logic transmit_wait_state0,
    // Transmit link side
    output tai_lnk_word_t lnk_word,
    output logic lnk_valid,
    input wire logic lnk_ready,
    // Receive buffer side
    input wire logic rxb_valid,
    input wire tai_rx_hdr_t rxb_hdr,
    output logic rxb_pop,
    output logic rxb_credit_release,
    // Receive application side, channel 0
    output logic rx_req0,
    output logic [DESC_W-1:0] rx_desc0,
    input wire logic rx_ack0,
    input wire logic rx_abort0,
    input wire logic rx_retry0,
    input wire logic rx_mask0
);

    localparam int PTR_W = $clog2(TX_BUF_DEPTH);
    localparam int FILL_W = $clog2(TX_BUF_DEPTH + 1);
    localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(TX_BUF_DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(TX_BUF_DEPTH - 1);
    localparam logic [1:0] PHASE_FREE = 2'(TX_FREE_PHASES);

    // ==========================================================================
    // Functions
    // ==========================================================================
    function automatic logic is_completion(input logic [HDR_W-1:0] h);
        return h[HDR_TYPE_HI:HDR_TYPE_LO] == TYPE_CPL;
    endfunction

    function automatic logic has_payload(input logic [HDR_W-1:0] h);
        return h[DESC_HAS_DATA];
    endfunction

    function automatic logic is_nonposted(input logic [HDR_W-1:0] h);
        logic msg;
        logic mem_write;
        msg = h[HDR_TYPE_HI -: 2] == TYPE_MSG_TOP;
        mem_write = (h[HDR_TYPE_HI:HDR_TYPE_LO] == TYPE_MEM) && has_payload(h);
        return !is_completion(h) && !msg && !mem_write;
    endfunction

    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                  input logic [DATA_W-1:0] w);
        logic [CRC_W-1:0] r;
        r = c;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            r = (r[CRC_W-1] ^ w[i]) ? ((r << 1) ^ LCRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic en);
        return en ? c + CNT_W'(1) : c;
    endfunction

    // ==========================================================================
    // State
    // ==========================================================================
    logic [1:0] ctrl_reg, ctrl_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [CNT_W-1:0] tx_pkts_reg, tx_pkts_next, tx_null_reg, tx_null_next;
    logic [CNT_W-1:0] rx_acks_reg, rx_acks_next, rx_aborts_reg, rx_aborts_next;

    tai_rx_state_t rx_state_reg, rx_state_next;
    logic [DESC_W-1:0] rx_desc_reg, rx_desc_next;
    logic rx_take;

    tai_tx_state_t tx_state_reg, tx_state_next;
    logic [HDR_W-1:0] tx_hdr_reg, tx_hdr_next;
    logic err_reg, err_next;
    logic open_reg, open_next;
    logic [1:0] phase_reg, phase_next;
    logic [CRC_W-1:0] crc_reg, crc_next;
    tai_lnk_word_t lnk_word_reg, lnk_word_next;
    logic lnk_valid_reg, lnk_valid_next;
    tai_tx_entry_t tx_buf [TX_BUF_DEPTH];
    logic [PTR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [FILL_W-1:0] fill_reg, fill_next;
    logic ack_now, slot, buf_wr, buf_rd;

    // ==========================================================================
    // APB slave
    // ==========================================================================
    logic setup, wr_strobe, mapped;

    assign setup = psel && !penable;
    assign wr_strobe = psel && penable && pwrite;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                    (paddr == REG_TX_PKTS) || (paddr == REG_TX_NULL) ||
                    (paddr == REG_RX_ACKS) || (paddr == REG_RX_ABORTS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        prdata_next = prdata_reg;
        if (wr_strobe && (paddr == REG_CTRL)) begin
            ctrl_next = pwdata[1:0];
        end
        if (setup && !pwrite) begin
            prdata_next = '0;
            case (paddr)
                REG_CTRL: prdata_next[1:0] = ctrl_reg;
                REG_STATUS: begin
                    prdata_next[STAT_TX_LO +: 3] = tx_state_reg;
                    prdata_next[STAT_RX_LO +: 2] = rx_state_reg;
                    prdata_next[STAT_TXCNT_LO +: FILL_W] = fill_reg;
                end
                REG_TX_PKTS: prdata_next[CNT_W-1:0] = tx_pkts_reg;
                REG_TX_NULL: prdata_next[CNT_W-1:0] = tx_null_reg;
                REG_RX_ACKS: prdata_next[CNT_W-1:0] = rx_acks_reg;
                REG_RX_ABORTS: prdata_next[CNT_W-1:0] = rx_aborts_reg;
                default: prdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RESET;
            prdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            prdata_reg <= prdata_next;
        end
    end

    // ==========================================================================
    // Receive descriptor phase
    // ==========================================================================
    // Presented while receive is enabled, except non-posted headers while rx_mask0 is set.
    assign rx_take = rxb_valid && ctrl_reg[CTRL_RX_EN] &&
                     !(rx_mask0 && is_nonposted(rxb_hdr.hdr));
    assign rx_req0 = rx_state_reg != RX_IDLE;
    assign rx_desc0 = rx_desc_reg;

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_desc_next = rx_desc_reg;
        rxb_pop = 1'b0;
        rxb_credit_release = 1'b0;
        rx_acks_next = rx_acks_reg;
        rx_aborts_next = rx_aborts_reg;
        case (rx_state_reg)
            RX_IDLE: begin
                if (rx_take) begin
                    rx_state_next = RX_FIRST;
                    rx_desc_next = '0;
                    rx_desc_next[HDR_W-1:DESC_FIRST_LO] = rxb_hdr.hdr[HDR_W-1:DESC_FIRST_LO];
                    rx_desc_next[DESC_HAS_DATA] = has_payload(rxb_hdr.hdr);
                end
            end
            RX_FIRST: begin
                rx_state_next = RX_HOLD;
                rx_desc_next[DESC_FIRST_LO-1:0] = rxb_hdr.hdr[DESC_FIRST_LO-1:0];
                rx_desc_next[DESC_W-1:HDR_W] = rxb_hdr.dec;
                rx_desc_next[HDR_W + DEC_RESERVED] = 1'b0;
                if (is_completion(rxb_hdr.hdr)) begin
                    rx_desc_next[DESC_W-1:HDR_W] = '0;
                end
            end
            RX_HOLD: begin
                if (rx_ack0) begin
                    rx_state_next = RX_IDLE;
                    rxb_pop = 1'b1;
                    rx_acks_next = bump(rx_acks_reg, 1'b1);
                end else if (rx_abort0) begin
                    rx_state_next = RX_IDLE;
                    rxb_pop = 1'b1;
                    rxb_credit_release = 1'b1;
                    rx_aborts_next = bump(rx_aborts_reg, 1'b1);
                end else if (rx_retry0) begin
                    rx_state_next = RX_IDLE;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_state_reg <= RX_IDLE;
            rx_desc_reg <= '0;
            rx_acks_reg <= '0;
            rx_aborts_reg <= '0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_desc_reg <= rx_desc_next;
            rx_acks_reg <= rx_acks_next;
            rx_aborts_reg <= rx_aborts_next;
        end
    end

    // ==========================================================================
    // Transmit application side and buffer
    // ==========================================================================
    // First phases never wait.
    // Wait while the buffer is full.
    assign transmit_wait_state0 = open_reg && (phase_reg >= PHASE_FREE) &&
                                  (fill_reg == FILL_FULL);
    assign buf_wr = open_reg && tx_dv0 && !transmit_wait_state0;
    assign ack_now = ((tx_state_reg == TX_IDLE) && tx_req0 && ctrl_reg[CTRL_TX_EN] &&
                      !tx_desc0[HDR_FMT_4DW]) || (tx_state_reg == TX_PAD);
    assign tx_ack0 = ack_now;
    assign slot = !lnk_valid_reg || lnk_ready;
    assign buf_rd = (tx_state_reg == TX_DATA) && slot && (fill_reg != '0);
    assign lnk_word = lnk_word_reg;
    assign lnk_valid = lnk_valid_reg;

    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        fill_next = fill_reg;
        phase_next = phase_reg;
        open_next = open_reg;
        if (buf_wr) begin
            wptr_next = (wptr_reg == PTR_LAST) ? '0 : wptr_reg + PTR_W'(1);
            if (phase_reg < PHASE_FREE) begin
                phase_next = phase_reg + 2'h1;
            end
            if (!tx_dfr0) begin
                open_next = 1'b0;
            end
        end
        if (buf_rd) begin
            rptr_next = (rptr_reg == PTR_LAST) ? '0 : rptr_reg + PTR_W'(1);
        end
        fill_next = fill_reg + FILL_W'(buf_wr) - FILL_W'(buf_rd);
        if (ack_now) begin
            open_next = has_payload(tx_desc0);
            phase_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (buf_wr) begin
            tx_buf[wptr_reg] <= '{last: !tx_dfr0, data: tx_data0};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            fill_reg <= '0;
            phase_reg <= '0;
            open_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            fill_reg <= fill_next;
            phase_reg <= phase_next;
            open_reg <= open_next;
        end
    end

    // ==========================================================================
    // Transmit link sequencer
    // ==========================================================================
    always_comb begin
        tai_tx_entry_t head;
        head = tx_buf[rptr_reg];
        tx_state_next = tx_state_reg;
        tx_hdr_next = tx_hdr_reg;
        err_next = err_reg;
        crc_next = crc_reg;
        lnk_word_next = lnk_word_reg;
        lnk_valid_next = lnk_valid_reg && !lnk_ready;
        tx_pkts_next = tx_pkts_reg;
        tx_null_next = tx_null_reg;
        if (open_reg && tx_err0) begin
            err_next = 1'b1;
        end
        case (tx_state_reg)
            TX_IDLE: begin
                if (tx_req0 && ctrl_reg[CTRL_TX_EN] && tx_desc0[HDR_FMT_4DW]) begin
                    tx_state_next = TX_PAD;
                end
            end
            TX_PAD: tx_state_next = TX_HDR0;
            TX_HDR0: begin
                if (slot) begin
                    lnk_word_next = '{kind: LK_HDR, data: tx_hdr_reg[HDR_W-1:DESC_FIRST_LO]};
                    lnk_valid_next = 1'b1;
                    crc_next = crc_step(crc_reg, tx_hdr_reg[HDR_W-1:DESC_FIRST_LO]);
                    tx_state_next = TX_HDR1;
                end
            end
            TX_HDR1: begin
                if (slot) begin
                    lnk_word_next = '{kind: LK_HDR, data: tx_hdr_reg[DESC_FIRST_LO-1:0]};
                    lnk_valid_next = 1'b1;
                    crc_next = crc_step(crc_reg, tx_hdr_reg[DESC_FIRST_LO-1:0]);
                    tx_state_next = has_payload(tx_hdr_reg) ? TX_DATA : TX_CRC;
                end
            end
            TX_DATA: begin
                if (buf_rd) begin
                    lnk_word_next = '{kind: LK_DATA, data: head.data};
                    lnk_valid_next = 1'b1;
                    crc_next = crc_step(crc_reg, head.data);
                    if (head.last) begin
                        tx_state_next = TX_CRC;
                    end
                end
            end
            TX_CRC: begin
                if (slot) begin
                    lnk_word_next.kind = LK_LCRC;
                    lnk_word_next.data = DATA_W'(err_reg ? ~crc_reg : crc_reg);
                    lnk_valid_next = 1'b1;
                    tx_state_next = TX_END;
                end
            end
            TX_END: begin
                if (slot) begin
                    lnk_word_next = '{kind: err_reg ? LK_EDB : LK_END, data: '0};
                    lnk_valid_next = 1'b1;
                    tx_pkts_next = bump(tx_pkts_reg, 1'b1);
                    tx_null_next = bump(tx_null_reg, err_reg);
                    tx_state_next = TX_IDLE;
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
        if (ack_now) begin
            tx_hdr_next = tx_desc0;
            err_next = 1'b0;
            crc_next = LCRC_INIT;
            tx_state_next = TX_HDR0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_state_reg <= TX_IDLE;
            tx_hdr_reg <= '0;
            err_reg <= 1'b0;
            crc_reg <= LCRC_INIT;
            lnk_word_reg <= '{kind: LK_NONE, data: '0};
            lnk_valid_reg <= 1'b0;
            tx_pkts_reg <= '0;
            tx_null_reg <= '0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_hdr_reg <= tx_hdr_next;
            err_reg <= err_next;
            crc_reg <= crc_next;
            lnk_word_reg <= lnk_word_next;
            lnk_valid_reg <= lnk_valid_next;
            tx_pkts_reg <= tx_pkts_next;
            tx_null_reg <= tx_null_next;
        end
    end

endmodule

//--- testbench/tai_core_asserts.sv
// Purpose: Port assertions for the receive descriptor handshake.
// Assumes: One clock, reset active low.
// Notes: Bound to every core instance.
`timescale 1ns/100ps
module tai_core_asserts
    import tai_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Receive buffer and application
    input wire tai_rx_hdr_t rxb_hdr,
    input wire logic rxb_pop,
    input wire logic rxb_credit_release,
    input wire logic rx_req0,
    input wire logic [DESC_W-1:0] rx_desc0,
    input wire logic rx_ack0,
    input wire logic rx_abort0,
    input wire logic rx_retry0
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_held;
        rx_req0 && $past(rx_req0);
    endsequence
    sequence s_done;
        s_held ##0 (rx_ack0 || rx_abort0 || rx_retry0);
    endsequence
    AST_REQ_TWO: assert property ($rose(rx_req0) |=> rx_req0)
        else $error("request too short");
    AST_UPPER: assert property ($rose(rx_req0) |=> $stable(rx_desc0[127:64]))
        else $error("upper half moved");
    AST_HOLD: assert property (s_held ##0 !(rx_ack0 || rx_abort0 || rx_retry0)
        |=> rx_req0 && $stable(rx_desc0)) else $error("descriptor not held");
    AST_DROP: assert property (s_done |=> !rx_req0)
        else $error("request kept after answer");
    AST_POP: assert property (s_held ##0 (rx_ack0 || rx_abort0)
        |-> rxb_pop && rxb_credit_release == !rx_ack0) else $error("bad release");
    AST_BODY: assert property (s_held |-> rx_desc0[125:0] == rxb_hdr.hdr[125:0])
        else $error("header field changed");
    AST_CPL: assert property (s_held ##0 rx_desc0[124:120] == TYPE_CPL
        |-> rx_desc0[135:128] == 8'h00) else $error("completion decode set");
    AST_RSVD: assert property (s_held |-> !rx_desc0[135])
        else $error("reserved decode set");
endmodule

bind tai_core tai_core_asserts u_chk (
    .clk, .rstn, .rxb_hdr, .rxb_pop, .rxb_credit_release, .rx_req0, .rx_desc0,
    .rx_ack0, .rx_abort0, .rx_retry0
);

//--- testbench/tai_app_model.sv
// Purpose: Application responder for receive descriptors.
// Assumes: rsp_dly is at least 1.
// Notes: Mode 0 acks, 1 aborts, 2 retries and holds the mask.
`timescale 1ns/100ps
module tai_app_model (
    // Clock, reset and bench control
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] rsp_mode,
    input wire logic [3:0] rsp_dly,
    // Receive answers
    input wire logic rx_req0,
    output logic rx_ack0,
    output logic rx_abort0,
    output logic rx_retry0,
    output logic rx_mask0
);
    logic [3:0] cnt_reg;
    logic ans_reg;
    logic msk_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 4'h0;
            ans_reg <= 1'b0;
            msk_reg <= 1'b0;
        end else begin
            ans_reg <= rx_req0 && !ans_reg && cnt_reg + 4'h1 == rsp_dly;
            cnt_reg <= (rx_req0 && !ans_reg) ? cnt_reg + 4'h1 : 4'h0;
            msk_reg <= rsp_mode == 2'h2 && (msk_reg || ans_reg);
        end
    end
    assign rx_ack0 = ans_reg && rsp_mode == 2'h0;
    assign rx_abort0 = ans_reg && rsp_mode == 2'h1;
    assign rx_retry0 = ans_reg && rsp_mode == 2'h2;
    assign rx_mask0 = msk_reg || rx_retry0;
endmodule

//--- testbench/tai_core_test.sv
// Purpose: Self-checking bench for the packet interface core.
// Assumes: The responder model answers receive descriptors.
// Notes: Link words are logged by kind to check their order.
`timescale 1ns/100ps
module tai_core_test;
    import tai_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, c1;
    logic tx_req0 = 0, tx_dfr0 = 0, tx_dv0 = 0, tx_err0 = 0, tx_ack0, transmit_wait_state0;
    logic [HDR_W-1:0] tx_desc0 = '0;
    logic [DATA_W-1:0] tx_data0 = '0;
    tai_lnk_word_t lnk_word;
    logic lnk_valid, lnk_ready = 1, stall = 0, rxb_valid = 0, rxb_pop, rxb_credit_release;
    logic rx_req0, rx_ack0, rx_abort0, rx_retry0, rx_mask0;
    tai_rx_hdr_t rxb_hdr = '0;
    logic [DESC_W-1:0] rx_desc0;
    logic [1:0] rsp_mode = 0, cyc = 0;
    logic [3:0] rsp_dly = 1;
    logic [119:0] tl = 120'h0102030405060708090A0B0C0D0E0F;
    int fails = 0, tests_run = 0, ws;
    tai_lnk_kind_t kq[$];
    logic [31:0] crc_q[$];

    tai_core u_dut (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .tx_req0, .tx_desc0, .tx_ack0, .tx_dfr0, .tx_dv0, .tx_data0,
        .tx_err0, .transmit_wait_state0, .lnk_word, .lnk_valid, .lnk_ready, .rxb_valid,
        .rxb_hdr, .rxb_pop, .rxb_credit_release, .rx_req0, .rx_desc0, .rx_ack0,
        .rx_abort0, .rx_retry0, .rx_mask0);
    tai_app_model u_app (.clk, .rstn, .rsp_mode, .rsp_dly, .rx_req0, .rx_ack0,
        .rx_abort0, .rx_retry0, .rx_mask0);

    initial begin
        forever #50 clk = ~clk;
    end
    // Link sink stalls on three cycles of four while stall is set.
    always @(posedge clk) begin
        cyc <= cyc + 2'h1;
        lnk_ready <= !stall || cyc == 2'h0;
        if (lnk_valid && lnk_ready) kq.push_back(lnk_word.kind);
        if (lnk_valid && lnk_ready && lnk_word.kind == LK_LCRC) crc_q.push_back(lnk_word.data[31:0]);
    end
    initial begin
        #(3000 * 100);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        tally_and_finish();
    end

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic step(ref int k);
        @(posedge clk);
        k++;
    endtask
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w = 1'b0,
                       input logic [31:0] d = 32'h0);
        int k = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do step(k); while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic tx_pkt(input logic four, input int n, input logic err);
        int k = 0;
        ws = 0;
        kq.delete();
        tx_req0 <= 1'b1;
        tx_desc0 <= {2'b01, four, 125'h0};
        do step(k); while (tx_ack0 !== 1'b1 && k < 20);
        chk(k == (four ? 2 : 1), "ack delay");
        tx_req0 <= 1'b0;
        for (int i = 0; i < n; i++) begin
            tx_dv0 <= 1'b1;
            tx_data0 <= 64'(i);
            tx_dfr0 <= i != n - 1;
            tx_err0 <= err;
            do begin
                step(k);
                if (transmit_wait_state0 === 1'b1) ws += (i < 2) ? 1000 : 1;
            end while (transmit_wait_state0 !== 1'b0 && k < 300);
        end
        tx_dv0 <= 1'b0;
        tx_err0 <= 1'b0;
        while (kq.size() < n + 4 && k < 400) step(k);
        chk(kq.size() == n + 4 && kq[0] === LK_HDR && kq[n + 2] === LK_LCRC, "order");
        chk(kq[$] === (err ? LK_EDB : LK_END), "end marker");
        chk(ws < 1000, "early wait");
    endtask
    task automatic rx_pkt(input logic [HDR_W-1:0] h, input logic [7:0] d, xd, input logic [1:0] m);
        int k = 0;
        rsp_mode <= m;
        rxb_hdr <= '{h, d};
        rxb_valid <= 1'b1;
        do step(k); while (rx_req0 !== 1'b1 && k < 20);
        chk(rx_desc0[127:64] === h[127:64], "upper half late");
        @(posedge clk);
        chk(rx_req0 === 1'b1 && rx_desc0 === {xd, h}, "descriptor");
        while (rxb_pop !== 1'b1 && k < 40) step(k);
        chk(rxb_pop === 1'b1 && rxb_credit_release === (m == 2'h1), "release");
        rxb_valid <= 1'b0;
        @(posedge clk);
        chk(rx_req0 === 1'b0, "request kept");
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========
    // Scenarios.
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        apb(REG_CTRL);
        chk(rd === 32'h3 && er === 1'b0, "ctrl reset");
        apb(12'hFF0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped");
        apb(REG_CTRL, 1'b1, 32'h2);
        chk(er === 1'b0, "ctrl write refused");
        apb(REG_CTRL);
        chk(rd === 32'h2, "ctrl write lost");
        apb(REG_CTRL, 1'b1, 32'h3);
        tx_pkt(1'b0, 2, 1'b0);
        c1 = crc_q[$];
        tx_pkt(1'b0, 2, 1'b1);
        chk(crc_q[$] === ~c1, "check not inverted");
        tx_pkt(1'b1, 3, 1'b0);
        stall <= 1'b1;
        tx_pkt(1'b0, 8, 1'b0);
        chk(ws > 0, "no throttle");
        stall <= 1'b0;
        apb(REG_TX_NULL);
        chk(rd === 32'h1, "null count");
        rx_pkt({8'h4A, tl}, 8'hFF, 8'h00, 2'h0);
        rx_pkt({8'h40, tl}, 8'h81, 8'h01, 2'h1);
        rsp_mode <= 2'h2;
        rxb_hdr <= '{{8'h00, tl}, 8'h02};
        rxb_valid <= 1'b1;
        repeat (12) @(posedge clk);
        chk(rx_req0 === 1'b0 && rxb_pop === 1'b0, "masked read shown");
        rsp_dly <= 4'h3;
        rx_pkt({8'h00, tl}, 8'h02, 8'h02, 2'h0);
        apb(REG_RX_ACKS);
        chk(rd === 32'h2, "ack count");
        apb(REG_RX_ABORTS);
        chk(rd === 32'h1, "abort count");
        tally_and_finish();
    end
endmodule
